// ---- verilog/bmw_consts.svh ----
// Purpose: Constants for the burst write FIFO port
// Assumes: Single user clock, 40 MHz
// Notes:   Widths are fixed; memory-side beats pack into one user word
`ifndef BMW_CONSTS_SVH
`define BMW_CONSTS_SVH

`define BMW_ADDR_W 24
`define BMW_CMD_W 3
`define BMW_DATA_W 72
`define BMW_FIFO_DEPTH 8
`define BMW_BL_W 2
`define BMW_BL4 2'h1
`define BMW_BL8 2'h2
`define BMW_WORDS_BL4 3'h2
`define BMW_WORDS_BL8 3'h4
`define BMW_FETCH_TO_DRAIN 2

`endif

// ---- verilog/bmw_pkg.sv ----
// Purpose: Types for the burst write FIFO port
// Assumes: Constants come from bmw_consts.svh
// Notes:   Binary state codes written out
package bmw_pkg;
    typedef enum logic [1:0] {
        BMW_ST_IDLE = 2'h0,
        BMW_ST_ANALYZE = 2'h1,
        BMW_ST_DRAIN = 2'h2
    } bmw_state_t;
endpackage : bmw_pkg

// ---- verilog/bmw_fifo.sv ----
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: One clock, DEPTH a power of two
// Notes:   Read data comes straight from the storage flops
`timescale 1ns/1ps
module bmw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready_o = (cnt_q != DEPTH[PW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_ptr_q];
    assign level_o = cnt_q;

    always_comb begin
        wr_ptr_d = wr_ptr_q + PW'(push);
        rd_ptr_d = rd_ptr_q + PW'(pop);
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset; reads are guarded by the count
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    overflow_guard_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i) cnt_q <= DEPTH[PW:0])
        else $error("fifo count exceeds depth");
endmodule : bmw_fifo

// ---- verilog/bmw_write_port.sv ----
// Purpose: Write-side user port: command FIFO, data FIFO, burst sequencer
// Assumes: User logic keeps the push pairing for the configured burst
// Notes:   Fetch to first data pop is two clocks when the data is already queued
//
// Behaviour
// - Data popping starts two clocks after fetch, or later if the user pushes late.
// - Command and address fetched as one entry before any burst data.
// - Command analysis finishes within two clocks before data drain starts.
// - Burst of eight pops its four data words on consecutive clocks when all four are queued.
`timescale 1ns/1ps
`include "bmw_consts.svh"
module bmw_write_port
    import bmw_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Configuration
    input wire logic [`BMW_BL_W-1:0] burst_len_i,
    // User command side
    input wire logic addr_fifo_push_strobe_i,
    input wire logic [`BMW_ADDR_W-1:0] user_cmd_address_i,
    input wire logic [`BMW_CMD_W-1:0] user_cmd_code_i,
    output logic addr_fifo_full_o,
    // User data side
    input wire logic wdata_fifo_push_strobe_i,
    input wire logic [`BMW_DATA_W-1:0] user_write_word_i,
    output logic wdata_fifo_full_o,
    // Memory side
    input wire logic mem_ready_i,
    output logic mem_cmd_valid_o,
    output logic [`BMW_ADDR_W-1:0] mem_cmd_address_o,
    output logic [`BMW_CMD_W-1:0] mem_cmd_code_o,
    output logic mem_wdata_valid_o,
    output logic [`BMW_DATA_W-1:0] mem_wdata_o,
    output logic mem_wdata_last_o
);
    localparam int EW = `BMW_ADDR_W + `BMW_CMD_W;
    localparam int LW = $clog2(`BMW_FIFO_DEPTH) + 1;

    function automatic logic [2:0] words_per_burst(
        input logic [`BMW_BL_W-1:0] bl
    );
        // Unknown encodings fall back to the short burst
        words_per_burst = (bl == `BMW_BL8) ? `BMW_WORDS_BL8 : `BMW_WORDS_BL4;
    endfunction : words_per_burst

    logic cmd_ready, cmd_valid, cmd_in_ready;
    logic [EW-1:0] cmd_entry;
    logic dat_valid, dat_pop, dat_in_ready;
    logic [`BMW_DATA_W-1:0] dat_word;
    logic [LW-1:0] dat_level;
    logic fetch;

    bmw_state_t state_q, state_d;
    logic [2:0] left_q, left_d;
    logic cv_q, cv_d, dv_q, dv_d, dl_q, dl_d;
    logic [`BMW_ADDR_W-1:0] ca_q, ca_d;
    logic [`BMW_CMD_W-1:0] cc_q, cc_d;
    logic [`BMW_DATA_W-1:0] dw_q, dw_d;

    // Back-pressure to the user; full stops further pushes
    assign addr_fifo_full_o = !cmd_in_ready;
    assign wdata_fifo_full_o = !dat_in_ready;

    bmw_fifo #(.WIDTH(EW), .DEPTH(`BMW_FIFO_DEPTH)) u_cmd_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(addr_fifo_push_strobe_i),
        .in_ready_o(cmd_in_ready),
        .in_data_i({user_cmd_code_i, user_cmd_address_i}),
        .out_valid_o(cmd_valid),
        .out_ready_i(cmd_ready),
        .out_data_o(cmd_entry),
        .level_o()
    );

    bmw_fifo #(.WIDTH(`BMW_DATA_W), .DEPTH(`BMW_FIFO_DEPTH)) u_dat_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(wdata_fifo_push_strobe_i),
        .in_ready_o(dat_in_ready),
        .in_data_i(user_write_word_i),
        .out_valid_o(dat_valid),
        .out_ready_i(dat_pop),
        .out_data_o(dat_word),
        .level_o(dat_level)
    );

    // Address and command leave the FIFO together, one entry per burst
    assign cmd_ready = (state_q == BMW_ST_IDLE) && mem_ready_i;
    assign fetch = cmd_ready && cmd_valid;
    // Data only drains after its command was fetched and analysed
    // Drain ignores mem_ready_i, so the sink must accept every word
    assign dat_pop = (state_q == BMW_ST_DRAIN) && dat_valid;

    always_comb begin
        state_d = state_q;
        left_d = left_q;
        cv_d = 1'b0;
        dv_d = 1'b0;
        dl_d = 1'b0;
        ca_d = ca_q;
        cc_d = cc_q;
        dw_d = dw_q;
        unique case (state_q)
            BMW_ST_IDLE: begin
                if (fetch) begin
                    cv_d = 1'b1;
                    ca_d = cmd_entry[`BMW_ADDR_W-1:0];
                    cc_d = cmd_entry[EW-1:`BMW_ADDR_W];
                    left_d = words_per_burst(burst_len_i);
                    state_d = BMW_ST_ANALYZE;
                end
            end
            BMW_ST_ANALYZE: begin
                // One analysis clock, so drain opens two clocks after fetch
                state_d = BMW_ST_DRAIN;
            end
            BMW_ST_DRAIN: begin
                // Pops run back to back while the user keeps up
                if (dat_pop) begin
                    dv_d = 1'b1;
                    dw_d = dat_word;
                    left_d = left_q - 3'h1;
                    if (left_q == 3'h1) begin
                        dl_d = 1'b1;
                        state_d = BMW_ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = BMW_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= BMW_ST_IDLE;
            left_q <= 3'h0;
            cv_q <= 1'b0;
            dv_q <= 1'b0;
            dl_q <= 1'b0;
            ca_q <= '0;
            cc_q <= '0;
            dw_q <= '0;
        end else begin
            state_q <= state_d;
            left_q <= left_d;
            cv_q <= cv_d;
            dv_q <= dv_d;
            dl_q <= dl_d;
            ca_q <= ca_d;
            cc_q <= cc_d;
            dw_q <= dw_d;
        end
    end

    assign mem_cmd_valid_o = cv_q;
    assign mem_cmd_address_o = ca_q;
    assign mem_cmd_code_o = cc_q;
    assign mem_wdata_valid_o = dv_q;
    assign mem_wdata_o = dw_q;
    assign mem_wdata_last_o = dl_q;

    sequence fetch_s;
        fetch;
    endsequence

    sequence analyse_s;
        ##1 (state_q == BMW_ST_ANALYZE) ##1 (state_q == BMW_ST_DRAIN);
    endsequence

    sequence pop_pair_s;
        dat_pop [*2];
    endsequence

    // Burst timing checks need the whole burst queued at fetch

    no_early_data_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i) dat_pop |-> state_q == BMW_ST_DRAIN)
        else $error("data popped before its command was fetched");

    analysis_time_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i) fetch_s |-> analyse_s)
        else $error("drain did not open two clocks after fetch");

    first_pop_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        fetch && dat_level >= LW'(1) |-> ##2 dat_pop)
        else $error("first data pop not two clocks after fetch");

    bl8_burst_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        fetch && burst_len_i == `BMW_BL8 && dat_level >= LW'(4)
        |-> ##2 dat_pop [*4] ##1 (state_q == BMW_ST_IDLE))
        else $error("burst of eight did not pop four consecutive words");

    cmd_output_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        fetch |=> mem_cmd_valid_o
            && mem_cmd_address_o == $past(cmd_entry[`BMW_ADDR_W-1:0])
            && mem_cmd_code_o == $past(cmd_entry[EW-1:`BMW_ADDR_W]))
        else $error("fetched command not presented");

    // Single-clock pulses let a sink count them without edge logic
    cmd_pulse_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i) mem_cmd_valid_o |=> !mem_cmd_valid_o)
        else $error("command valid held longer than one clock");

    data_output_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        dat_pop |=> mem_wdata_valid_o && mem_wdata_o == $past(dat_word))
        else $error("popped word not presented");

    last_flag_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        mem_wdata_last_o |-> mem_wdata_valid_o && state_q == BMW_ST_IDLE)
        else $error("last flag outside the final word of a burst");

    bl4_burst_a: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        fetch && burst_len_i == `BMW_BL4 && dat_level >= LW'(2)
        |-> ##2 pop_pair_s ##1 (state_q == BMW_ST_IDLE))
        else $error("burst of four did not pop two consecutive words");
endmodule : bmw_write_port

// ---- testbench/bmw_user_model.sv ----
// Purpose: User logic model filling the command and data FIFOs
// Assumes: Drives at the falling edge, one push per push_cmd or push_word call
// Notes:   Idle lines show the inverse of the last value
`timescale 1ns/1ps
`include "bmw_consts.svh"
module bmw_user_model (
    // Clock
    input wire logic ref_clk_i,
    // FIFO status
    input wire logic addr_full_i,
    input wire logic wdata_full_i,
    // Pushes
    output logic cmd_push_o,
    output logic [`BMW_ADDR_W-1:0] cmd_addr_o,
    output logic [`BMW_CMD_W-1:0] cmd_code_o,
    output logic word_push_o,
    output logic [`BMW_DATA_W-1:0] word_o
);
    initial begin
        cmd_push_o = 1'b0;
        cmd_addr_o = '0;
        cmd_code_o = '0;
        word_push_o = 1'b0;
        word_o = '0;
    end

    task automatic push_cmd(input logic [23:0] a, input logic [2:0] c);
        @(negedge ref_clk_i);
        while (addr_full_i) @(negedge ref_clk_i);
        cmd_push_o = 1'b1;
        cmd_addr_o = a;
        cmd_code_o = c;
        @(negedge ref_clk_i);
        cmd_push_o = 1'b0;
        cmd_addr_o = ~a;
        cmd_code_o = ~c;
    endtask : push_cmd

    // Skip lets a scenario push into a full FIFO on purpose
    task automatic push_word(input logic [71:0] d, input bit skip);
        @(negedge ref_clk_i);
        while (!skip && wdata_full_i) @(negedge ref_clk_i);
        word_push_o = 1'b1;
        word_o = d;
        @(negedge ref_clk_i);
        word_push_o = 1'b0;
        word_o = ~d;
    endtask : push_word

    task automatic push_burst(input logic [23:0] a, input logic [2:0] c,
        input int n, input logic [71:0] d, input int gap);
        push_cmd(a, c);
        repeat (gap) @(negedge ref_clk_i);
        for (int k = 0; k < n; k++) push_word(d + 72'(k), 1'b0);
    endtask : push_burst
endmodule : bmw_user_model

// ---- testbench/burst_memory_write_fifo_port_tb_top.sv ----
// Purpose: Self-checking bench for the burst write FIFO port
// Assumes: Memory side samples outputs at the rising edge
// Notes:   Monitor records cycle stamps of every output pulse
`timescale 1ns/1ps
`include "bmw_consts.svh"
module burst_memory_write_fifo_port_tb_top;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] blen = `BMW_BL8;
    logic mem_ready = 1'b0;
    logic cpush, wpush, afull, wfull, cval, wval, wlast;
    logic [23:0] caddr, maddr;
    logic [2:0] ccode, mcode;
    logic [71:0] word, mdata;
    int cyc = 0, err_total = 0, total_checks = 0;
    int cmd_cyc[$], wd_cyc[$];
    logic [26:0] cmd_adr[$];
    logic [71:0] wd_dat[$];
    logic wd_last[$];

    always #12.5 ref_clk = ~ref_clk;

    bmw_write_port dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .burst_len_i(blen), .addr_fifo_push_strobe_i(cpush),
        .user_cmd_address_i(caddr), .user_cmd_code_i(ccode),
        .addr_fifo_full_o(afull), .wdata_fifo_push_strobe_i(wpush),
        .user_write_word_i(word), .wdata_fifo_full_o(wfull),
        .mem_ready_i(mem_ready), .mem_cmd_valid_o(cval),
        .mem_cmd_address_o(maddr), .mem_cmd_code_o(mcode),
        .mem_wdata_valid_o(wval), .mem_wdata_o(mdata),
        .mem_wdata_last_o(wlast));

    bmw_user_model u_user (.ref_clk_i(ref_clk), .addr_full_i(afull),
        .wdata_full_i(wfull), .cmd_push_o(cpush), .cmd_addr_o(caddr),
        .cmd_code_o(ccode), .word_push_o(wpush), .word_o(word));

    always @(posedge ref_clk) begin
        cyc++;
        if (cval === 1'b1) begin
            cmd_cyc.push_back(cyc);
            cmd_adr.push_back({mcode, maddr});
        end
        if (wval === 1'b1) begin
            wd_cyc.push_back(cyc);
            wd_dat.push_back(mdata);
            wd_last.push_back(wlast);
        end
        if (cyc > 2000) begin
            err_total++;
            summarize();
        end
    end

    task automatic chk(input string n, input logic [71:0] e,
        input logic [71:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic start(input logic [1:0] bl, input logic rdy);
        cmd_cyc.delete();
        cmd_adr.delete();
        wd_cyc.delete();
        wd_dat.delete();
        wd_last.delete();
        blen = bl;
        mem_ready = rdy;
    endtask : start

    task automatic wait_words(input int n);
        for (int i = 0; i < 100 && wd_cyc.size() < n; i++) @(negedge ref_clk);
        chk("words", 72'(n), 72'(wd_cyc.size()));
    endtask : wait_words

    // Data preloaded so the pops can run back to back
    task automatic sc_bl8;
        start(`BMW_BL8, 1'b0);
        for (int k = 0; k < 4; k++) u_user.push_word(72'h1000 + 72'(k), 1'b0);
        u_user.push_cmd(24'hA5A5A5, 3'h3);
        repeat (3) @(negedge ref_clk);
        chk("cmd_held", 72'h0, 72'(cmd_cyc.size()));
        mem_ready = 1'b1;
        wait_words(4);
        chk("cmd", {3'h3, 24'hA5A5A5}, 72'(cmd_adr[0]));
        for (int k = 0; k < 4; k++) begin
            chk("gap", 72'(2 + k), 72'(wd_cyc[k] - cmd_cyc[0]));
            chk("data", 72'h1000 + 72'(k), wd_dat[k]);
            chk("last", 72'(k == 3), 72'(wd_last[k]));
        end
    endtask : sc_bl8

    // First word pushed two clocks after its command arrives just in time
    task automatic sc_bl4_late;
        start(`BMW_BL4, 1'b1);
        u_user.push_burst(24'h00F00F, 3'h1, 2, 72'hCAFE, 0);
        wait_words(2);
        chk("cmd_n", 72'h1, 72'(cmd_cyc.size()));
        chk("lag", 72'h2, 72'(wd_cyc[0] - cmd_cyc[0]));
        for (int k = 0; k < 2; k++) begin
            chk("data", 72'hCAFE + 72'(k), wd_dat[k]);
            chk("last", 72'(k == 1), 72'(wd_last[k]));
        end
        // Undefined burst codes behave as the short burst
        blen = 2'h3;
        u_user.push_burst(24'h00A00A, 3'h5, 2, 72'hBEE0, 0);
        wait_words(4);
        chk("cmd", {3'h5, 24'h00A00A}, 72'(cmd_adr[1]));
        for (int k = 2; k < 4; k++) begin
            chk("data", 72'hBEE0 + 72'(k - 2), wd_dat[k]);
            chk("last", 72'(k == 3), 72'(wd_last[k]));
        end
    endtask : sc_bl4_late

    // Memory side stalls while both FIFOs fill, then drains
    task automatic sc_fill;
        start(`BMW_BL4, 1'b0);
        for (int k = 0; k < 8; k++) u_user.push_cmd(24'h100 + 24'(k), 3'h2);
        for (int k = 0; k < 8; k++) u_user.push_word(72'h2000 + 72'(k), 1'b0);
        chk("afull", 72'h1, 72'(afull));
        chk("wfull", 72'h1, 72'(wfull));
        u_user.push_word(72'hBAD0, 1'b1);
        mem_ready = 1'b1;
        wait_words(8);
        // Remaining four commands get their words while the drain waits
        for (int k = 0; k < 8; k++) begin
            u_user.push_word(72'h2008 + 72'(k), 1'b0);
        end
        wait_words(16);
        for (int k = 0; k < 16; k++) begin
            chk("data", 72'h2000 + 72'(k), wd_dat[k]);
            chk("last", 72'(k % 2), 72'(wd_last[k]));
        end
        for (int k = 0; k < 8; k++) begin
            chk("cmd", {3'h2, 24'h100 + 24'(k)}, 72'(cmd_adr[k]));
        end
        repeat (10) @(negedge ref_clk);
        chk("dropped", 72'h10, 72'(wd_cyc.size()));
        reset_n = 1'b0;
        @(negedge ref_clk);
        chk("rst_out", 72'h0, 72'({afull, wfull, cval, wval, wlast}));
        reset_n = 1'b1;
    endtask : sc_fill

    task automatic summarize;
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    initial begin
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        sc_bl8();
        sc_bl4_late();
        sc_fill();
        sc_bl8();
        summarize();
    end
endmodule : burst_memory_write_fifo_port_tb_top
